// *** rtl/fqr_params.svh ***
`ifndef FQR_PARAMS_SVH
`define FQR_PARAMS_SVH

// ---------------------------------------------
// Query table indices (byte address = 4 * index)
// ---------------------------------------------
`define FQR_IDX_FIELDS 9'h128
`define FQR_IDX_CAP1 9'h129
`define FQR_IDX_CAP2 9'h12A
`define FQR_IDX_CAP3 9'h12B
`define FQR_IDX_CAP4 9'h12C
`define FQR_IDX_REGIONS 9'h12D
`define FQR_IDX_INFO 9'h12E
`define FQR_IDX_IDENT 9'h130
`define FQR_IDX_OPS_IN 9'h132
`define FQR_IDX_OPS_PG 9'h133
`define FQR_IDX_OPS_ER 9'h134
`define FQR_IDX_ERTYPES 9'h135
`define FQR_IDX_BLK 9'h136
`define FQR_IDX_LAST 9'h139

// ---------------------------------------------
// Fixed query contents
// ---------------------------------------------
`define FQR_FIELDS_VAL 8'h04
`define FQR_CAP1_VAL 8'h01
`define FQR_CAP2_VAL 8'h02
`define FQR_CAP3_VAL 8'h03
`define FQR_CAP4_VAL 8'h07
`define FQR_CONT_CODE 3'h7

// ---------------------------------------------
// Burst configuration and status registers
// ---------------------------------------------
`define FQR_CFG_ADDR 12'h000
`define FQR_STAT_ADDR 12'h004
`define FQR_CFG_RST 3'h7
`define FQR_STAT_CONT 8
`define FQR_STAT_OK 9

`endif

// *** rtl/fqr_pkg.sv ***
package fqr_pkg;

   // ------------------------------------------
   // Bus request carrier and address slots
   // ------------------------------------------
   typedef struct packed {
      logic [11:0] addr;
      logic write;
      logic [31:0] wdata;
   } fqr_apb_req_t;

   typedef enum logic [1:0] {
      FQR_SLOT_QUERY = 2'b00,
      FQR_SLOT_CFG = 2'b01,
      FQR_SLOT_STAT = 2'b10,
      FQR_SLOT_NONE = 2'b11
   } fqr_slot_t;

endpackage : fqr_pkg

// *** rtl/fqr_query_rom.sv ***
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "fqr_params.svh"
// Behaviour
// RULE_01: First capability byte holds n in bits 0-2; bits 3-7 read zero.
// RULE_02: Capability code 07h means continuous linear burst to space end.
// RULE_03: Host may copy a 3-bit capability code into burst config bits.
// RULE_04: First three capability bytes read 01, 02, 03 (4, 8, 16 words).
// RULE_05: Fourth capability byte at index 12C reads 07.
// RULE_06: Region count is zero for one partition, then no fields follow.
// RULE_07: Two-byte info size counts locations including itself.
// RULE_08: Two-byte field gives identical partitions in the region.
// RULE_09: Ops within partition: program count bits 0-3, erase bits 4-7.
// RULE_10: Same nibble layout for ops allowed while programming.
// RULE_11: Same nibble layout for ops allowed while erasing.
// RULE_12: Erase region type zero means bulk erase, else region count.
// RULE_13: Block descriptor: y+1 blocks in bits 0-15, z*256 in 16-31.
// RULE_14: Index 128 reports four capability fields follow.
// RULE_15: Query bytes on low lanes, upper lanes zero, writes ignored.
module fqr_query_rom
   import fqr_pkg::*;
#(
   parameter logic [7:0] REGION_COUNT = 8'h01,
   parameter logic [15:0] INFO_SIZE = 16'h0018,
   parameter logic [15:0] IDENT_PARTS = 16'h0001,
   parameter logic [7:0] OPS_WITHIN = 8'h11,
   parameter logic [7:0] OPS_DURING_PG = 8'h00,
   parameter logic [7:0] OPS_DURING_ER = 8'h00,
   parameter logic [7:0] ERASE_REGIONS = 8'h01,
   parameter logic [15:0] BLK_COUNT_M1 = 16'h00FF,
   parameter logic [15:0] BLK_SIZE_Z = 16'h0200
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB request.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // APB answer.
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata
);

   // ------------------------------------------
   // Query content lookup
   // ------------------------------------------

   // Returns the constant byte at one query index.
   function automatic logic [7:0] fqr_query(
      input logic [8:0] idx
   );
      logic [7:0] b;
      logic [31:0] blk;
      b = 8'h00;
      blk = {BLK_SIZE_Z, BLK_COUNT_M1};
      case (idx)
         // RULE_14 four fields follow
         `FQR_IDX_FIELDS: b = `FQR_FIELDS_VAL;
         // RULE_01 first capability code
         `FQR_IDX_CAP1: b = `FQR_CAP1_VAL;
         // RULE_04 eight and sixteen words
         `FQR_IDX_CAP2: b = `FQR_CAP2_VAL;
         `FQR_IDX_CAP3: b = `FQR_CAP3_VAL;
         // RULE_05 continuous burst code
         `FQR_IDX_CAP4: b = `FQR_CAP4_VAL;
         `FQR_IDX_REGIONS: b = REGION_COUNT;
         // RULE_07 info size field
         `FQR_IDX_INFO: b = INFO_SIZE[7:0];
         9'h12F: b = INFO_SIZE[15:8];
         // RULE_08 identical partition count
         `FQR_IDX_IDENT: b = IDENT_PARTS[7:0];
         9'h131: b = IDENT_PARTS[15:8];
         // RULE_09 ops within partition
         `FQR_IDX_OPS_IN: b = OPS_WITHIN;
         // RULE_10 ops while programming
         `FQR_IDX_OPS_PG: b = OPS_DURING_PG;
         // RULE_11 ops while erasing
         `FQR_IDX_OPS_ER: b = OPS_DURING_ER;
         // RULE_12 erase region types
         `FQR_IDX_ERTYPES: b = ERASE_REGIONS;
         // RULE_13 block descriptor bytes
         `FQR_IDX_BLK: b = blk[7:0];
         9'h137: b = blk[15:8];
         9'h138: b = blk[23:16];
         `FQR_IDX_LAST: b = blk[31:24];
         default: b = 8'h00;
      endcase
      // RULE_06 single partition device
      // A single-partition part has no region fields after the count.
      if (REGION_COUNT == 8'h00 && idx > `FQR_IDX_REGIONS) begin
         b = 8'h00;
      end
      // RULE_12 bulk erase region
      // A bulk-erased region carries no block descriptor.
      if (ERASE_REGIONS == 8'h00 && idx >= `FQR_IDX_BLK) begin
         b = 8'h00;
      end
      return b;
   endfunction : fqr_query

   // Maps a byte address onto a register slot.
   function automatic fqr_slot_t fqr_decode(
      input logic [11:0] a
   );
      fqr_slot_t s;
      s = FQR_SLOT_NONE;
      if (a == `FQR_CFG_ADDR) begin
         s = FQR_SLOT_CFG;
      end else if (a == `FQR_STAT_ADDR) begin
         s = FQR_SLOT_STAT;
      end else if (a[1:0] == 2'b00 &&
                   a[11:2] >= {1'b0, `FQR_IDX_FIELDS} &&
                   a[11:2] <= {1'b0, `FQR_IDX_LAST}) begin
         s = FQR_SLOT_QUERY;
      end
      return s;
   endfunction : fqr_decode

   // ------------------------------------------
   // Request capture and decode
   // ------------------------------------------

   fqr_apb_req_t req;
   fqr_slot_t slot;
   logic setup_phase;
   logic access_phase;
   logic [2:0] burst_cfg;
   logic [9:0] status;
   logic [9:0] next_status;
   logic [31:0] next_prdata;
   logic code_ok;

   // Bundle the request so decode sees one carrier.
   assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
   assign slot = fqr_decode(req.addr);
   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;

   // Read data is ready from the setup cycle, so no wait states.
   assign pready = 1'b1;

   // RULE_15 writes never alter query
   // Writes to the table or status, and unmapped addresses, are errored.
   assign pslverr = access_phase &&
      (slot == FQR_SLOT_NONE ||
       (req.write && slot != FQR_SLOT_CFG));

   // ------------------------------------------
   // Burst configuration register
   // ------------------------------------------

   // RULE_03 host copies capability code
   // Only bits 0-2 are kept; the code lands unchanged.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_cfg <= `FQR_CFG_RST;
      end else if (access_phase && req.write &&
                   slot == FQR_SLOT_CFG) begin
         burst_cfg <= req.wdata[2:0];
      end
   end

   // ------------------------------------------
   // Burst status decode
   // ------------------------------------------

   // Check the chosen code against every advertised capability byte.
   always_comb begin
      code_ok = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (fqr_query(9'(`FQR_IDX_CAP1 + i)) ==
             {5'b0_0000, burst_cfg}) begin
            code_ok = 1'b1;
         end
      end
   end

   // RULE_01 length is two to n plus one
   // RULE_02 code seven is continuous
   always_comb begin
      next_status = 10'h000;
      next_status[`FQR_STAT_OK] = code_ok;
      if (burst_cfg == `FQR_CONT_CODE) begin
         next_status[`FQR_STAT_CONT] = 1'b1;
      end else begin
         next_status[7:0] = 8'(9'h001 << (burst_cfg + 3'h1));
      end
   end

   // Status follows the configuration one cycle later.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= 10'h000;
      end else begin
         status <= next_status;
      end
   end

   // ------------------------------------------
   // Read data path
   // ------------------------------------------

   // RULE_15 low lane query data
   // Upper lanes stay zero for every query location.
   always_comb begin
      next_prdata = 32'h0000_0000;
      case (slot)
         FQR_SLOT_QUERY: begin
            next_prdata[7:0] = fqr_query(req.addr[10:2]);
         end
         FQR_SLOT_CFG: begin
            next_prdata[2:0] = burst_cfg;
         end
         FQR_SLOT_STAT: begin
            next_prdata[9:0] = status;
         end
         default: begin
            next_prdata = 32'h0000_0000;
         end
      endcase
   end

   // Loaded in the setup cycle so the access phase answers at once.
   // A status read in the cycle after a config write sees old status.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase && !req.write) begin
         prdata <= next_prdata;
      end
   end

   // ------------------------------------------
   // Checks
   // ------------------------------------------

   sequence s_rd(logic [11:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence

   sequence s_acc;
      psel && penable && pready;
   endsequence

   sequence s_wr_cfg;
      psel && penable && pwrite && paddr == `FQR_CFG_ADDR;
   endsequence

   chk_fields_four: assert property ( // RULE_14
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_FIELDS, 2'b00}) ##1 s_acc
      |-> prdata == 32'h0000_0004)
      else $error("field count is not four");

   chk_cap_one: assert property ( // RULE_01
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_CAP1, 2'b00}) ##1 s_acc
      |-> prdata == 32'h0000_0001)
      else $error("first capability byte wrong");

   chk_cap_three: assert property ( // RULE_04
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_CAP3, 2'b00}) ##1 s_acc
      |-> prdata == 32'h0000_0003)
      else $error("third capability byte wrong");

   chk_cap_four: assert property ( // RULE_05
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_CAP4, 2'b00}) ##1 s_acc
      |-> prdata == 32'h0000_0007 && !pslverr)
      else $error("continuous code not advertised");

   chk_region_cnt: assert property ( // RULE_06
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_REGIONS, 2'b00}) ##1 s_acc
      |-> prdata[7:0] == REGION_COUNT)
      else $error("region count wrong");

   chk_info_low: assert property ( // RULE_07
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_INFO, 2'b00}) ##1 s_acc
      |-> prdata[7:0] ==
          (REGION_COUNT == 8'h00 ? 8'h00 : INFO_SIZE[7:0]))
      else $error("info size low byte wrong");

   chk_ops_within: assert property ( // RULE_09
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_OPS_IN, 2'b00}) ##1 s_acc
      |-> prdata[3:0] == OPS_WITHIN[3:0] &&
          prdata[7:4] == OPS_WITHIN[7:4])
      else $error("ops nibbles wrong");

   chk_blk_size: assert property ( // RULE_13
      @(posedge pclk) disable iff (!presetn)
      s_rd({9'h138, 2'b00}) ##1 s_acc
      |-> prdata[7:0] == (REGION_COUNT == 8'h00 ||
          ERASE_REGIONS == 8'h00 ? 8'h00 : BLK_SIZE_Z[7:0]))
      else $error("block size low byte wrong");

   chk_upper_zero: assert property ( // RULE_15
      @(posedge pclk) disable iff (!presetn)
      s_acc and (!pwrite && fqr_decode(paddr) == FQR_SLOT_QUERY)
      |-> prdata[31:8] == 24'h00_0000)
      else $error("upper lanes not zero");

   chk_rom_write: assert property ( // RULE_15
      @(posedge pclk) disable iff (!presetn)
      s_acc and (pwrite && fqr_decode(paddr) == FQR_SLOT_QUERY)
      |-> pslverr ##1 $stable(burst_cfg))
      else $error("query write not refused");

   chk_cap_two: assert property ( // RULE_04
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_CAP2, 2'b00}) ##1 s_acc
      |-> prdata == 32'h0000_0002)
      else $error("second capability byte wrong");

   chk_info_high: assert property ( // RULE_07
      @(posedge pclk) disable iff (!presetn)
      s_rd({9'h12F, 2'b00}) ##1 s_acc
      |-> prdata[7:0] ==
          (REGION_COUNT == 8'h00 ? 8'h00 : INFO_SIZE[15:8]))
      else $error("info size high byte wrong");

   chk_ident_low: assert property ( // RULE_08
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_IDENT, 2'b00}) ##1 s_acc
      |-> prdata[7:0] ==
          (REGION_COUNT == 8'h00 ? 8'h00 : IDENT_PARTS[7:0]))
      else $error("identical partition count wrong");

   chk_ops_program: assert property ( // RULE_10
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_OPS_PG, 2'b00}) ##1 s_acc
      |-> prdata[7:0] ==
          (REGION_COUNT == 8'h00 ? 8'h00 : OPS_DURING_PG))
      else $error("ops while programming wrong");

   chk_ops_erase: assert property ( // RULE_11
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_OPS_ER, 2'b00}) ##1 s_acc
      |-> prdata[7:0] ==
          (REGION_COUNT == 8'h00 ? 8'h00 : OPS_DURING_ER))
      else $error("ops while erasing wrong");

   chk_erase_types: assert property ( // RULE_12
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_ERTYPES, 2'b00}) ##1 s_acc
      |-> prdata[7:0] ==
          (REGION_COUNT == 8'h00 ? 8'h00 : ERASE_REGIONS))
      else $error("erase region type count wrong");

   chk_blk_count: assert property ( // RULE_13
      @(posedge pclk) disable iff (!presetn)
      s_rd({`FQR_IDX_BLK, 2'b00}) ##1 s_acc
      |-> prdata[7:0] == (REGION_COUNT == 8'h00 ||
          ERASE_REGIONS == 8'h00 ? 8'h00 : BLK_COUNT_M1[7:0]))
      else $error("block count low byte wrong");

   chk_cfg_write: assert property ( // RULE_03
      @(posedge pclk) disable iff (!presetn)
      s_wr_cfg |=> burst_cfg == 3'($past(pwdata)))
      else $error("config write did not land");

   chk_status_len: assert property ( // RULE_01
      @(posedge pclk) disable iff (!presetn)
      s_wr_cfg ##1 burst_cfg == 3'h1
      |-> ##1 status[7:0] == 8'h04 && !status[`FQR_STAT_CONT])
      else $error("burst length status wrong");

   chk_ok_flag: assert property ( // RULE_04
      @(posedge pclk) disable iff (!presetn)
      s_wr_cfg ##1 burst_cfg == 3'h3
      |-> ##1 status[`FQR_STAT_OK] && status[7:0] == 8'h10)
      else $error("advertised code not flagged");

   chk_cont_flag: assert property ( // RULE_02
      @(posedge pclk) disable iff (!presetn)
      s_wr_cfg ##1 burst_cfg == `FQR_CONT_CODE
      |-> ##1 status[`FQR_STAT_CONT] && status[7:0] == 8'h00)
      else $error("continuous status missing");

endmodule : fqr_query_rom

// *** test/fqr_host_model.sv ***
`timescale 1ns/1ps
module fqr_host_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Command from the bench.
   input wire logic req,
   input wire logic [11:0] addr,
   input wire logic wr,
   input wire logic [31:0] wd,
   // APB request.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   // APB answer.
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   // Result to the bench.
   output logic done,
   output logic [31:0] rdata,
   output logic err
);
   // ------------------------------------------
   // Transfer sequencer
   // ------------------------------------------
   // The request stands until pready is seen high; on release paddr and pwdata are
   // inverted so that no stale address or data can pass for a live one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psel <= 1'b0;
         penable <= 1'b0;
         pwrite <= 1'b0;
         paddr <= 12'h000;
         pwdata <= 32'h0000_0000;
         done <= 1'b0;
         rdata <= 32'h0000_0000;
         err <= 1'b0;
      end else begin
         done <= 1'b0;
         if (psel && penable && pready) begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b1;
            rdata <= prdata;
            err <= pslverr;
            paddr <= ~paddr;
            pwdata <= ~pwdata;
         end else if (psel) begin
            penable <= 1'b1;
         end else if (req) begin
            psel <= 1'b1;
            paddr <= addr;
            pwrite <= wr;
            pwdata <= wd;
         end
      end
   end
endmodule : fqr_host_model

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
   import fqr_pkg::*;
   // ------------------------------------------
   // Signals and table contents
   // ------------------------------------------
   localparam logic [15:0] INFO = 16'h0018;
   localparam logic [15:0] IDNT = 16'h0001;
   localparam logic [15:0] BLKY = 16'h00FF;
   localparam logic [15:0] BLKZ = 16'h0200;
   logic pclk = 1'b0;
   logic presetn, req, wr, psel, penable, pwrite, pready, pslverr;
   logic done, err;
   logic [11:0] addr, paddr;
   logic [31:0] wd, pwdata, prdata, rdata;
   logic [2:0] code;
   logic [2:0] codes [7] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h0, 3'h5, 3'h6};
   int miscompares = 0;
   int n_compared = 0;
   int to_cnt = 0;

   // Clock at 10 MHz.
   always #50 pclk = ~pclk;

   fqr_query_rom #(.REGION_COUNT(8'h01), .INFO_SIZE(INFO),
      .IDENT_PARTS(IDNT), .OPS_WITHIN(8'h11), .OPS_DURING_PG(8'h00),
      .OPS_DURING_ER(8'h00), .ERASE_REGIONS(8'h01),
      .BLK_COUNT_M1(BLKY), .BLK_SIZE_Z(BLKZ)) fqr_query_rom_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata));

   fqr_host_model fqr_host_model_i (
      .pclk(pclk), .presetn(presetn), .req(req), .addr(addr), .wr(wr),
      .wd(wd), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .done(done), .rdata(rdata), .err(err));

   // ------------------------------------------
   // Helpers
   // ------------------------------------------
   // Expected byte of each query index, little endian in wide fields.
   function automatic logic [7:0] exp_q(input logic [8:0] i);
      case (i)
         9'h128: return 8'h04;
         9'h129: return 8'h01;
         9'h12A: return 8'h02;
         9'h12B: return 8'h03;
         9'h12C: return 8'h07;
         9'h12D: return 8'h01;
         9'h12E: return INFO[7:0];
         9'h12F: return INFO[15:8];
         9'h130: return IDNT[7:0];
         9'h131: return IDNT[15:8];
         9'h132: return 8'h11;
         9'h135: return 8'h01;
         9'h136: return BLKY[7:0];
         9'h137: return BLKY[15:8];
         9'h138: return BLKZ[7:0];
         9'h139: return BLKZ[15:8];
         default: return 8'h00;
      endcase
   endfunction : exp_q

   // Status: burst words 2^(n+1), zero and flag for continuous code.
   function automatic logic [31:0] exp_st(input logic [2:0] c);
      if (c == 3'h7) return 32'h0000_0300;
      return (32'h0000_0001 << (c + 1)) |
         ((c inside {3'h1, 3'h2, 3'h3}) ? 32'h0000_0200 : 32'h0000_0000);
   endfunction : exp_st

   task report_and_stop;
      if (miscompares == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   task chk32(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %0t data got %h exp %h", $time, g, e);
      end
   endtask : chk32

   task chk1(input logic g, input logic e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %0t error flag got %b exp %b", $time, g, e);
      end
   endtask : chk1

   // One transfer through the host model, waiting for its completion.
   task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      addr <= a;
      wr <= w;
      wd <= d;
      req <= 1'b1;
      @(posedge pclk);
      req <= 1'b0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (done !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         report_and_stop;
      end
   endtask : xfer

   // A hang ends the run as a failure.
   always @(posedge pclk) begin
      to_cnt <= to_cnt + 1;
      if (to_cnt == 2000) begin
         miscompares++;
         report_and_stop;
      end
   end

   // ------------------------------------------
   // Test sequence
   // ------------------------------------------
   initial begin
      presetn = 1'b0;
      req = 1'b0;
      wr = 1'b0;
      addr = 12'h000;
      wd = 32'h0000_0000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      xfer(12'h000, 1'b0, 32'h0000_0000);
      chk32(rdata, 32'h0000_0007);
      xfer(12'h004, 1'b0, 32'h0000_0000);
      chk32(rdata, 32'h0000_0300);
      // Whole table, upper lanes zero.
      for (int i = 'h128; i <= 'h139; i++) begin
         xfer(12'(i * 4), 1'b0, 32'h0000_0000);
         chk32(rdata, {24'h00_0000, exp_q(9'(i))});
         chk1(err, 1'b0);
      end
      xfer(12'h4A4, 1'b0, 32'h0000_0000);
      chk32(32'h0000_0001 << (rdata[2:0] + 1), 32'h0000_0004);
      // Writes to the table are refused and change nothing.
      xfer(12'h4B0, 1'b1, 32'hFFFF_FFFF);
      chk1(err, 1'b1);
      xfer(12'h4B0, 1'b0, 32'h0000_0000);
      chk32(rdata, 32'h0000_0007);
      xfer(12'h500, 1'b0, 32'h0000_0000);
      chk1(err, 1'b1);
      xfer(12'h4A5, 1'b0, 32'h0000_0000);
      chk1(err, 1'b1);
      // Capability code copied straight into the config field.
      xfer(12'h4AC, 1'b0, 32'h0000_0000);
      xfer(12'h000, 1'b1, {29'h0000_0000, rdata[2:0]});
      xfer(12'h004, 1'b0, 32'h0000_0000);
      chk32(rdata, 32'h0000_0210);
      // Every burst code except 4, upper write bits ignored.
      for (int k = 0; k < 7; k++) begin
         code = codes[k];
         xfer(12'h000, 1'b1, {29'h1FFF_FFFF, code});
         chk1(err, 1'b0);
         xfer(12'h000, 1'b0, 32'h0000_0000);
         chk32(rdata, {29'h0000_0000, code});
         xfer(12'h004, 1'b0, 32'h0000_0000);
         chk32(rdata, exp_st(code));
      end
      report_and_stop;
   end
endmodule : tb
